// >>> vref_train_consts.svh
// constants for the dq reference training link
`ifndef VREF_TRAIN_CONSTS_SVH
`define VREF_TRAIN_CONSTS_SVH
`define REF_CLK_PS 4000
`define LINK_CLK_PS 32000
`define ENTRY_DELAY_NS 150
`define EXIT_DELAY_NS 150
`define SETTLE_NS 150
`define ENTRY_CYCLES ((`ENTRY_DELAY_NS * 1000 + `LINK_CLK_PS - 1) / `LINK_CLK_PS)
`define EXIT_CYCLES ((`EXIT_DELAY_NS * 1000 + `LINK_CLK_PS - 1) / `LINK_CLK_PS)
`define SETTLE_CYCLES ((`SETTLE_NS * 1000 + `LINK_CLK_PS - 1) / `LINK_CLK_PS)
`define LINK_DIV_HALF 4
`define MR_ENABLE_BIT 7
`define MR_RANGE_BIT 6
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_LEVEL 12'h008
`define REG_DEVICE 12'h00C
`define CTRL_START 0
`define CTRL_LEVEL 1
`define CTRL_EXIT 2
`define CTRL_RANGE 3
`define CTRL_PDA 4
`define CTRL_ACCESS 5
`define CTRL_ACT 6
`define CTRL_WR 7
`define CTRL_RD 8
`define CTRL_PRE 9
`endif

// >>> vref_train_pkg.sv
// command codes shared by both ends of the training link, and the controller's sequencer states
package vref_train_pkg;
    typedef enum logic [3:0] {
        CMD_DES = 4'h0,
        CMD_MRS = 4'h1,
        CMD_ACT = 4'h2,
        CMD_WR = 4'h3,
        CMD_WRA = 4'h4,
        CMD_RD = 4'h5,
        CMD_RDA = 4'h6,
        CMD_PRE = 4'h7
    } cmd_t;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ENTRY = 5'h02,
        ST_TRAIN = 5'h04,
        ST_SETTLE = 5'h08,
        ST_EXIT = 5'h10
    } ctl_state_t;
endpackage

// >>> vref_link_if.sv
// command link between controller and device
`timescale 1ns/1ps
interface vref_link_if;
    logic link_clk; // link clock, made by the controller
    vref_train_pkg::cmd_t cmd; // command code per link cycle
    logic [7:0] addr; // reference mode register payload
    logic dq0; // per-device select bit, low executes
    modport ctrl (output link_clk, output cmd, output addr, output dq0);
    modport dev (input link_clk, input cmd, input addr, input dq0);
endinterface

// >>> vref_dev.sv
// device end: reference mode register, training state and reference level
`timescale 1ns/1ps
`include "vref_train_consts.svh"
module vref_dev (
    vref_link_if.dev link,
    input wire logic arst_n_in,
    input wire logic pda_en_in,
    output logic train_active_out,
    output logic range_out,
    output logic [5:0] level_out,
    output logic [15:0] access_count_out
);
    // the device runs wholly on the link clock
    logic [1:0] pda_sync; // mode pin resynchronised, it is set from another clock
    wire is_mrs = link.cmd == vref_train_pkg::CMD_MRS;
    // per-device mode: only a low dq0 lets the write through
    wire mrs_taken = is_mrs && (!pda_sync[1] || !link.dq0);
    wire enable_bit = link.addr[`MR_ENABLE_BIT];
    wire is_access = link.cmd != vref_train_pkg::CMD_DES && !is_mrs;
    // two flops on the mode pin; only the second one is read by logic
    always_ff @(posedge link.link_clk or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pda_sync <= 2'h0;
        end else begin
            pda_sync <= {pda_sync[0], pda_en_in};
        end
    end
    // training flag follows bit 7 of each accepted write
    always_ff @(posedge link.link_clk or negedge arst_n_in) begin
        if (!arst_n_in) begin
            train_active_out <= 1'b0;
        end else if (mrs_taken) begin
            train_active_out <= enable_bit;
        end
    end
    // range and level change only when bit 7 is set; exit keeps the last ones
    always_ff @(posedge link.link_clk or negedge arst_n_in) begin
        if (!arst_n_in) begin
            range_out <= 1'b0;
            level_out <= 6'h00;
        end else if (mrs_taken && enable_bit) begin
            range_out <= link.addr[`MR_RANGE_BIT];
            level_out <= link.addr[5:0];
        end
    end
    // counts row and column traffic, a stand-in for the array's activity
    always_ff @(posedge link.link_clk or negedge arst_n_in) begin
        if (!arst_n_in) begin
            access_count_out <= 16'h0000;
        end else if (is_access) begin
            access_count_out <= access_count_out + 16'h0001;
        end
    end
endmodule

// >>> vref_ctrl.sv
// controller end: axi4-lite registers, training sequencer on a divided link clock
`timescale 1ns/1ps
`include "vref_train_consts.svh"
module vref_ctrl (
    vref_link_if.ctrl link,
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ---------- register side, ref clock ----------
    logic [5:0] level; // level to program
    logic req_tgl; // toggles once per order
    logic [9:0] req_op; // order bits, stable while a toggle crosses
    logic busy; // order outstanding
    logic [1:0] ack_sync; // ack toggle synchroniser
    logic ack_seen; // last ack toggle taken
    logic [1:0] act_sync; // training-active level synchroniser
    logic [1:0] bank_sync; // banks-open level synchroniser
    logic [6:0] fault_cnt; // control or level writes dropped while busy, saturating to fit the status field
    logic aw_held; // write address taken
    logic w_held; // write data taken
    logic [11:0] aw_addr; // held write address
    logic [35:0] w_data; // held write strobes and data, strobes on top
    logic ack_tgl; // completion toggle back to ref side, link clock
    logic active; // training on, link clock
    logic bank_open; // a row is open, link clock
    // decoding of the held write
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire wr_ctrl = aw_addr == `REG_CTRL;
    wire wr_level = aw_addr == `REG_LEVEL;
    wire wr_ok = wr_ctrl || wr_level;
    wire ack_evt = ack_sync[1] != ack_seen;
    wire order = wr_go && wr_ctrl && !busy && w_data[`CTRL_PRE:`CTRL_START] != 10'h000;
    wire order_lost = wr_go && (wr_ctrl || wr_level) && busy;
    // read decoding
    wire [31:0] status_word = {22'h000000, fault_cnt, bank_sync[1], act_sync[1], busy};
    wire rd_hit = s_axi_araddr == `REG_CTRL || s_axi_araddr == `REG_STATUS
        || s_axi_araddr == `REG_LEVEL;
    wire [31:0] rd_word = s_axi_araddr == `REG_STATUS ? status_word :
        s_axi_araddr == `REG_LEVEL ? {26'h0000000, level} :
        s_axi_araddr == `REG_CTRL ? {22'h000000, req_op} : 32'h00000000;
    // axi write channel capture; each channel released when taken
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 36'h000000000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[11:2], 2'h0};
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= {s_axi_wstrb, s_axi_wdata};
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end
    // readies and write response
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'h0 : 2'h2; // slverr on unmapped
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // read channel: one-cycle answer after the address is taken
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    // level register, order launch and completion; byte lane 0 only for level
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            level <= 6'h00;
            req_op <= 10'h000;
            req_tgl <= 1'b0;
            busy <= 1'b0;
            ack_seen <= 1'b0;
            fault_cnt <= 7'h00;
        end else begin
            // level is read by the link side, so it holds still while an order crosses
            if (wr_go && wr_level && w_data[32] && !busy) begin
                level <= w_data[5:0];
            end
            if (order) begin
                req_op <= w_data[`CTRL_PRE:`CTRL_START];
                req_tgl <= !req_tgl;
            end
            ack_seen <= ack_sync[1];
            // a new order and an ack never share a cycle since busy gates order
            busy <= order ? 1'b1 : ack_evt ? 1'b0 : busy;
            if (order_lost && fault_cnt != 7'h7F) begin
                fault_cnt <= fault_cnt + 7'h01;
            end
        end
    end
    // synchronisers into the ref domain
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ack_sync <= 2'h0;
            act_sync <= 2'h0;
            bank_sync <= 2'h0;
        end else begin
            ack_sync <= {ack_sync[0], ack_tgl};
            act_sync <= {act_sync[0], active};
            bank_sync <= {bank_sync[0], bank_open};
        end
    end
    // ---------- link clock made by a divider ----------
    logic [2:0] div_cnt; // divider count
    logic lclk; // divided link clock
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_cnt <= 3'h0;
            lclk <= 1'b0;
        end else if (div_cnt == 3'(`LINK_DIV_HALF - 1)) begin
            div_cnt <= 3'h0;
            lclk <= !lclk;
        end else begin
            div_cnt <= div_cnt + 3'h1;
        end
    end
    assign link.link_clk = lclk;
    // ---------- link side, link clock ----------
    vref_train_pkg::ctl_state_t state; // sequencer state
    logic [2:0] req_sync; // request toggle sync plus last value
    logic range; // range chosen at entry
    logic [4:0] wait_cnt; // delay down-counter
    vref_train_pkg::cmd_t cmd; // command out
    logic [7:0] addr; // payload out
    wire req_evt = req_sync[2] != req_sync[1];
    wire access_ok = !req_op[`CTRL_PDA];
    always_ff @(posedge lclk or negedge arst_n_in) begin
        if (!arst_n_in) begin
            req_sync <= 3'h0;
        end else begin
            req_sync <= {req_sync[1:0], req_tgl};
        end
    end
    // sequencer: one command per link cycle, deselect otherwise
    always_ff @(posedge lclk or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= vref_train_pkg::ST_IDLE;
            ack_tgl <= 1'b0;
            active <= 1'b0;
            range <= 1'b0;
            bank_open <= 1'b0;
            wait_cnt <= 5'h00;
            cmd <= vref_train_pkg::CMD_DES;
            addr <= 8'h00;
        end else begin
            cmd <= vref_train_pkg::CMD_DES;
            unique case (state)
                vref_train_pkg::ST_IDLE: begin
                    if (req_evt) begin
                        if (req_op[`CTRL_START] && !active) begin
                            cmd <= vref_train_pkg::CMD_MRS;
                            addr <= {1'b1, req_op[`CTRL_RANGE], 6'h00};
                            range <= req_op[`CTRL_RANGE];
                            active <= 1'b1;
                            wait_cnt <= 5'(`ENTRY_CYCLES - 1);
                            state <= vref_train_pkg::ST_ENTRY;
                        end else if (req_op[`CTRL_LEVEL] && active) begin
                            cmd <= vref_train_pkg::CMD_MRS;
                            addr <= {1'b1, range, level};
                            wait_cnt <= 5'(`SETTLE_CYCLES - 1);
                            state <= vref_train_pkg::ST_SETTLE;
                        end else if (req_op[`CTRL_EXIT] && active && !bank_open) begin
                            cmd <= vref_train_pkg::CMD_MRS;
                            addr <= {1'b0, range, level};
                            active <= 1'b0;
                            wait_cnt <= 5'(`EXIT_CYCLES - 1);
                            state <= vref_train_pkg::ST_EXIT;
                        end else if (active && access_ok) begin
                            if (req_op[`CTRL_ACT] && !bank_open) begin
                                cmd <= vref_train_pkg::CMD_ACT;
                                bank_open <= 1'b1;
                            end else if (req_op[`CTRL_WR] && bank_open) begin
                                cmd <= vref_train_pkg::CMD_WR;
                            end else if (req_op[`CTRL_RD] && bank_open) begin
                                cmd <= vref_train_pkg::CMD_RD;
                            end else if (req_op[`CTRL_PRE]) begin
                                cmd <= vref_train_pkg::CMD_PRE;
                                bank_open <= 1'b0;
                            end
                            ack_tgl <= !ack_tgl;
                        end else begin
                            ack_tgl <= !ack_tgl; // refused order completes with no command
                        end
                    end
                end
                vref_train_pkg::ST_ENTRY, vref_train_pkg::ST_SETTLE,
                vref_train_pkg::ST_EXIT: begin
                    if (wait_cnt == 5'h00) begin
                        ack_tgl <= !ack_tgl;
                        state <= vref_train_pkg::ST_IDLE;
                    end else begin
                        wait_cnt <= wait_cnt - 5'h01;
                    end
                end
                default: begin
                    state <= vref_train_pkg::ST_IDLE;
                end
            endcase
        end
    end
    assign link.cmd = cmd;
    assign link.addr = addr;
    assign link.dq0 = 1'b0; // every mode write targets this device
endmodule

// >>> vref_link_asserts.sv
// concurrent checks on the training link and the device's reference state
`timescale 1ns/1ps
module vref_link_asserts (
    input wire logic link_clk,
    input wire logic arst_n_in,
    input vref_train_pkg::cmd_t cmd,
    input wire logic [7:0] addr,
    input wire logic dq0,
    input wire logic train_active_out,
    input wire logic range_out,
    input wire logic [5:0] level_out
);
    logic bank_open; // set by an activate, cleared by any precharge
    wire is_mrs = cmd == vref_train_pkg::CMD_MRS; // mode write on the link
    wire enter = is_mrs && addr[7] && !train_active_out; // entry write
    wire set_lvl = is_mrs && addr[7] && train_active_out; // level write
    wire leave = is_mrs && !addr[7]; // exit write
    wire rng_bit = addr[6]; // range bit of the payload
    wire [5:0] lvl_bits = addr[5:0]; // level field of the payload
    wire closes = cmd == vref_train_pkg::CMD_PRE || cmd == vref_train_pkg::CMD_WRA
        || cmd == vref_train_pkg::CMD_RDA;

    // bank tracking; auto-precharge forms count as closing too
    always_ff @(posedge link_clk or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bank_open <= 1'b0;
        end else if (cmd == vref_train_pkg::CMD_ACT) begin
            bank_open <= 1'b1;
        end else if (closes) begin
            bank_open <= 1'b0;
        end
    end

    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!arst_n_in);

    // four deselects cover 128 ns; the next command lands at 160 ns at the earliest
    property p_enter_wait; enter |=> (cmd == vref_train_pkg::CMD_DES) [*4]; endproperty
    a_enter_wait: assert property (p_enter_wait) else $error("command inside entry delay");
    property p_enter_state; enter |=> train_active_out && range_out == $past(rng_bit); endproperty
    a_enter_state: assert property (p_enter_state) else $error("entry not taken");
    property p_level_value; set_lvl |=> level_out == $past(lvl_bits); endproperty
    a_level_value: assert property (p_level_value) else $error("level not stored");
    property p_level_range; set_lvl |-> rng_bit == range_out && addr[7]; endproperty
    a_level_range: assert property (p_level_range) else $error("range bit changed");
    property p_level_wait; set_lvl |=> (cmd == vref_train_pkg::CMD_DES) [*4]; endproperty
    a_level_wait: assert property (p_level_wait) else $error("command inside settle");
    property p_exit_hold;
        leave |=> !train_active_out && $stable(range_out) && $stable(level_out);
    endproperty
    a_exit_hold: assert property (p_exit_hold) else $error("exit altered level");
    property p_exit_idle; leave |-> !bank_open; endproperty
    a_exit_idle: assert property (p_exit_idle) else $error("exit with bank open");
    property p_exit_wait; leave |=> (cmd == vref_train_pkg::CMD_DES) [*4]; endproperty
    a_exit_wait: assert property (p_exit_wait) else $error("command inside exit delay");
    property p_dq0_low; is_mrs |-> !dq0; endproperty
    a_dq0_low: assert property (p_dq0_low) else $error("select bit high on mode write");

    c_enter: cover property (enter);
    c_level: cover property (set_lvl);
    c_exit: cover property (leave);
endmodule

// >>> tb.sv
// testbench: axi4-lite orders to the controller, device state checked at its outputs
`timescale 1ns/1ps
`include "vref_train_consts.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s expected %h got %h", nm, e, g); end end
module tb;
    logic ref_clk_in = 1'b0; // 4 ns system clock
    logic arst_n_in = 1'b0; // async reset, low active
    logic pda_en = 1'b0; // per-device addressing at the device
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd_data;
    logic dev_active, dev_range;
    logic [5:0] dev_level;
    logic [15:0] dev_count;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    // order words for the control register
    localparam logic [31:0] ENTER = 32'h1 << `CTRL_START;
    localparam logic [31:0] LVL = 32'h1 << `CTRL_LEVEL;
    localparam logic [31:0] EXIT = 32'h1 << `CTRL_EXIT;
    localparam logic [31:0] RNG = 32'h1 << `CTRL_RANGE;
    localparam logic [31:0] PER_DEVICE_ADDRESSING = 32'h1 << `CTRL_PDA;

    always #2 ref_clk_in = ~ref_clk_in;

    vref_link_if link ();
    vref_ctrl u_vref_ctrl (.link(link), .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    vref_dev u_vref_dev (.link(link), .arst_n_in(arst_n_in), .pda_en_in(pda_en),
        .train_active_out(dev_active), .range_out(dev_range), .level_out(dev_level),
        .access_count_out(dev_count));
    vref_link_asserts u_vref_link_asserts (.link_clk(link.link_clk), .arst_n_in(arst_n_in),
        .cmd(link.cmd), .addr(link.addr), .dq0(link.dq0), .train_active_out(dev_active),
        .range_out(dev_range), .level_out(dev_level));

    // verdict and end of run, reached from the main sequence or the watchdog
    task automatic print_verdict();
        if (mismatches == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // write: address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge ref_clk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        `CHK("bresp", er, bresp)
    endtask

    // read: data taken at the edge where rvalid is seen
    task automatic axi_rd(input logic [11:0] a, input logic [1:0] er);
        @(posedge ref_clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd_data = rdata;
        `CHK("rresp", er, rresp)
    endtask

    // one order, then poll busy; the last status read stays in rd_data
    task automatic order(input logic [31:0] v);
        axi_wr(`REG_CTRL, v, 2'h0);
        do axi_rd(`REG_STATUS, 2'h0);
        while (rd_data[0] !== 1'b0);
    endtask

    // watchdog: a hang counts as a mismatch
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        // reset held five cycles; the divider keeps the link clock low meanwhile
        repeat (5) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        axi_rd(`REG_STATUS, 2'h0);
        `CHK("status at reset", 32'h0, rd_data)
        axi_rd(12'h010, 2'h2);
        axi_wr(12'h010, 32'h0, 2'h2);
        // entry in range 2; an exit order while busy must be dropped
        axi_wr(`REG_CTRL, ENTER | RNG, 2'h0);
        order(EXIT);
        `CHK("active", 1'b1, dev_active)
        `CHK("range", 1'b1, dev_range)
        `CHK("status", 10'h00A, rd_data[9:0])
        order(32'h1 << `CTRL_ACT);
        order(32'h1 << `CTRL_WR);
        axi_wr(`REG_LEVEL, 32'h2A, 2'h0);
        order(LVL);
        `CHK("level", 6'h2A, dev_level)
        `CHK("range kept", 1'b1, dev_range)
        order(32'h1 << `CTRL_RD);
        // exit with a bank open is refused
        order(EXIT);
        `CHK("active open bank", 1'b1, dev_active)
        `CHK("bank open", 2'b11, rd_data[2:1])
        order(32'h1 << `CTRL_PRE);
        axi_wr(`REG_LEVEL, 32'h15, 2'h0);
        axi_rd(`REG_LEVEL, 2'h0);
        `CHK("level reg", 32'h15, rd_data)
        order(LVL);
        order(EXIT);
        `CHK("exited", 1'b0, dev_active)
        `CHK("final level", 6'h15, dev_level)
        `CHK("final range", 1'b1, dev_range)
        `CHK("accesses", 16'h0004, dev_count)
        // per-device mode: mode writes only, range 1
        pda_en <= 1'b1;
        order(ENTER | PER_DEVICE_ADDRESSING);
        `CHK("pda active", 1'b1, dev_active)
        `CHK("pda range", 1'b0, dev_range)
        order((32'h1 << `CTRL_ACT) | PER_DEVICE_ADDRESSING);
        `CHK("pda accesses", 16'h0004, dev_count)
        `CHK("pda bank", 1'b0, rd_data[2])
        axi_wr(`REG_LEVEL, 32'h3F, 2'h0);
        order(LVL | PER_DEVICE_ADDRESSING);
        order(EXIT | PER_DEVICE_ADDRESSING);
        `CHK("pda level", 6'h3F, dev_level)
        `CHK("pda exited", 1'b0, dev_active)
        print_verdict();
    end
endmodule
